// File: rtl/hist_mem_input_regs.sv
// histogram result readout and external-memory frame fetch registers
module hist_mem_input_regs
    import hist_regs_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  arst_n_i,
    // register port
    input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input  wire logic [REG_DATA_W-1:0] reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [REG_DATA_W-1:0] reg_rdata_o,
    // histogram engine result writes
    input  wire logic                    hist_wr_i,
    input  wire logic [ENTRY_IDX_W-1:0]  hist_wr_idx_i,
    input  wire logic [ENTRY_DATA_W-1:0] hist_wr_data_i,
    // frame control
    input  wire logic                  frame_start_i,
    output logic                       busy_o,
    output logic                       frame_done_o,
    // dma line read requests
    output logic                       dma_req_o,
    output logic [FETCH_ADDR_W-1:0]    dma_addr_o,
    output logic [SIZE_W-1:0]          dma_len_o,
    input  wire logic                  dma_ack_i
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [ENTRY_IDX_W-1:0]  idx_r;
    logic [ENTRY_IDX_W-1:0]  idx_nxt;
    logic [ENTRY_DATA_W-1:0] ram_q;
    logic [FETCH_ADDR_W-1:0] start_r;
    logic [STRIDE_W-1:0]     stride_r;
    logic [SIZE_W-1:0]       hsize_r;
    logic [SIZE_W-1:0]       lines_per_frame_r;
    logic [FETCH_ADDR_W-1:0] act_start_r;
    logic [STRIDE_W-1:0]     act_stride_r;
    logic [SIZE_W-1:0]       act_hsize_r;
    logic [SIZE_W-1:0]       act_lines_per_frame_r;
    logic [SIZE_W-1:0]       line_r;
    logic [FETCH_ADDR_W-1:0] line_addr_r;
    logic [REG_DATA_W-1:0]   rdata_r;
    logic                    done_r;
    fetch_state_e            state_r;
    logic                    wr_idx;
    logic                    launch;
    logic                    line_ack;
    logic                    last_line;

    assign wr_idx    = reg_wr_i && (reg_addr_i == OFS_ENTRY_INDEX);
    assign launch    = (state_r == FETCH_IDLE) && frame_start_i
                       && (hsize_r != RST_SIZE) && (lines_per_frame_r != RST_SIZE);
    assign line_ack  = (state_r == FETCH_REQ) && dma_ack_i;
    assign last_line = (line_r == act_lines_per_frame_r - SIZE_W'(1));

    // ------------------------------------------------------------------
    // result memory readout
    // ------------------------------------------------------------------
    // ram follows the next index so a read right after a write is fresh
    assign idx_nxt = wr_idx ? reg_wdata_i[ENTRY_IDX_W-1:0] : idx_r;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            idx_r <= RST_ENTRY_IDX;
        end
        else
        begin
            idx_r <= idx_nxt;
        end
    end

    hist_entry_ram #(
        .IDX_W  (ENTRY_IDX_W),
        .DATA_W (ENTRY_DATA_W)
    ) u_entry_ram (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .wr_en_i   (hist_wr_i),
        .wr_idx_i  (hist_wr_idx_i),
        .wr_data_i (hist_wr_data_i),
        .rd_idx_i  (idx_nxt),
        .rd_data_o (ram_q)
    );

    // ------------------------------------------------------------------
    // software-visible setup registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            start_r  <= RST_START;
            stride_r <= RST_STRIDE;
            hsize_r  <= RST_SIZE;
            lines_per_frame_r  <= RST_SIZE;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                OFS_FETCH_START:
                    start_r <= reg_wdata_i & START_MASK;
                OFS_LINE_STRIDE:
                    stride_r <= reg_wdata_i[STRIDE_W-1:0]
                                & STRIDE_MASK;
                OFS_FRAME_SIZE:
                begin
                    hsize_r <= reg_wdata_i[HSIZE_LSB +: SIZE_W];
                    lines_per_frame_r <= reg_wdata_i[LINES_PER_FRAME_LSB +: SIZE_W];
                end
                default:
                    ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read data, valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_r <= RD_ZERO;
        end
        else
        begin
            rdata_r <= RD_ZERO;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    OFS_ENTRY_INDEX:
                        rdata_r[ENTRY_IDX_W-1:0] <= idx_r;
                    OFS_ENTRY_VALUE:
                        rdata_r[ENTRY_DATA_W-1:0] <= ram_q;
                    OFS_FETCH_START:
                        rdata_r <= start_r;
                    OFS_LINE_STRIDE:
                        rdata_r[STRIDE_W-1:0] <= stride_r;
                    OFS_FRAME_SIZE:
                    begin
                        rdata_r[HSIZE_LSB +: SIZE_W] <= hsize_r;
                        rdata_r[LINES_PER_FRAME_LSB +: SIZE_W] <= lines_per_frame_r;
                    end
                    OFS_FETCH_STAT:
                    begin
                        rdata_r[STAT_BUSY] <= busy_o;
                        rdata_r[STAT_LINE_LSB +: SIZE_W] <= line_r;
                    end
                    default:
                        rdata_r <= RD_ZERO;
                endcase
            end
        end
    end

    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------------
    // frame shadows: setup captured only when a frame starts
    // ------------------------------------------------------------------
    // mid-frame writes must not tear the address walk of the current frame
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            act_start_r  <= RST_START;
            act_stride_r <= RST_STRIDE;
            act_hsize_r  <= RST_SIZE;
            act_lines_per_frame_r  <= RST_SIZE;
        end
        else if (launch)
        begin
            act_start_r  <= start_r;
            act_stride_r <= stride_r;
            act_hsize_r  <= hsize_r;
            act_lines_per_frame_r  <= lines_per_frame_r;
        end
    end

    // ------------------------------------------------------------------
    // line fetch sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_r <= FETCH_IDLE;
        end
        else
        begin
            case (state_r)
                FETCH_IDLE:
                    if (launch)
                        state_r <= FETCH_REQ;
                FETCH_REQ:
                    if (dma_ack_i)
                        state_r <= last_line ? FETCH_IDLE
                                             : FETCH_GAP;
                FETCH_GAP:
                    state_r <= FETCH_REQ;
                default:
                    state_r <= FETCH_IDLE;
            endcase
        end
    end

    // address steps by the stride after each accepted line except the last
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            line_r      <= RST_SIZE;
            line_addr_r <= RST_START;
        end
        else if (launch)
        begin
            line_r      <= RST_SIZE;
            line_addr_r <= start_r;
        end
        else if (line_ack && !last_line)
        begin
            line_r      <= line_r + SIZE_W'(1);
            line_addr_r <= line_addr_r
                           + {{(FETCH_ADDR_W-STRIDE_W){1'b0}},
                              act_stride_r};
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= line_ack && last_line;
        end
    end

    assign dma_req_o    = (state_r == FETCH_REQ);
    assign dma_addr_o   = line_addr_r;
    assign dma_len_o    = act_hsize_r;
    assign busy_o       = (state_r != FETCH_IDLE);
    assign frame_done_o = done_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    AST_INDEX_READBACK: assert property (
        wr_idx ##1 (reg_rd_i && reg_addr_i == OFS_ENTRY_INDEX)
        |=> reg_rdata_o == {22'h0, $past(reg_wdata_i[9:0], 2)})
        else $error("index readback differs from last write");

    AST_VALUE_UPPER_ZERO: assert property (
        (reg_rd_i && reg_addr_i == OFS_ENTRY_VALUE)
        |=> reg_rdata_o[31:20] == 12'h000
            && reg_rdata_o[19:0] == $past(ram_q))
        else $error("entry value read wrong");

    AST_START_READBACK: assert property (
        (reg_wr_i && reg_addr_i == OFS_FETCH_START)
        ##1 (reg_rd_i && reg_addr_i == OFS_FETCH_START)
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & START_MASK))
        else $error("start address readback wrong");

    AST_DMA_ALIGNED: assert property (
        dma_req_o |-> dma_addr_o[4:0] == 5'h00)
        else $error("line address not 32-byte aligned");

    AST_START_HELD_BUSY: assert property (
        (busy_o && reg_wr_i && reg_addr_i == OFS_FETCH_START)
        |=> act_start_r == $past(act_start_r))
        else $error("start changed during a frame");

    AST_STRIDE_HELD_BUSY: assert property (
        (busy_o && reg_wr_i && reg_addr_i == OFS_LINE_STRIDE)
        |=> act_stride_r == $past(act_stride_r)
            && stride_r[4:0] == 5'h00)
        else $error("stride changed during a frame");

    AST_FIRST_LINE: assert property (
        launch |=> dma_req_o && dma_addr_o == $past(start_r)
                   && dma_len_o == $past(hsize_r))
        else $error("first line request wrong");

    AST_LINE_STEP: assert property (
        (line_ack && !last_line)
        |=> !dma_req_o ##1 dma_req_o
            && dma_addr_o == $past(dma_addr_o, 2) + {16'h0, act_stride_r})
        else $error("line address did not step by stride");

    AST_FRAME_END: assert property (
        (line_ack && last_line) |=> !busy_o && frame_done_o
                                    && line_r == $past(act_lines_per_frame_r) - 14'h1)
        else $error("frame did not end after last line");

    COV_FRAME_DONE: cover property (frame_done_o);
    COV_BUSY_WRITE: cover property (
        busy_o && reg_wr_i && reg_addr_i == OFS_FETCH_START);
    COV_VALUE_READ: cover property (
        wr_idx ##1 (reg_rd_i && reg_addr_i == OFS_ENTRY_VALUE));

endmodule : hist_mem_input_regs

// File: include/hist_regs_pkg.sv
// constants shared by the histogram memory-input register bank
package hist_regs_pkg;

    // ------------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------------
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned REG_DATA_W = 32;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENTRY_INDEX = 8'h00;
    localparam logic [7:0] OFS_ENTRY_VALUE = 8'h04;
    localparam logic [7:0] OFS_FETCH_START = 8'h08;
    localparam logic [7:0] OFS_LINE_STRIDE = 8'h0C;
    localparam logic [7:0] OFS_FRAME_SIZE  = 8'h10;
    localparam logic [7:0] OFS_FETCH_STAT  = 8'h14;

    // ------------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------------
    localparam int unsigned ENTRY_IDX_W  = 10;
    localparam int unsigned ENTRY_DATA_W = 20;
    localparam int unsigned FETCH_ADDR_W = 32;
    localparam int unsigned STRIDE_W     = 16;
    localparam int unsigned SIZE_W       = 14;
    localparam int unsigned HSIZE_LSB    = 16;
    localparam int unsigned LINES_PER_FRAME_LSB    = 0;
    localparam int unsigned ALIGN_BITS   = 5;
    localparam int unsigned STAT_BUSY    = 31;
    localparam int unsigned STAT_LINE_LSB = 0;

    // low five address bits are forced to zero (32-byte alignment)
    localparam logic [31:0] START_MASK  = 32'hFFFF_FFE0;
    localparam logic [15:0] STRIDE_MASK = 16'hFFE0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [9:0]  RST_ENTRY_IDX = 10'h000;
    localparam logic [31:0] RST_START     = 32'h0000_0000;
    localparam logic [15:0] RST_STRIDE    = 16'h0000;
    localparam logic [13:0] RST_SIZE      = 14'h0000;
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

    // ------------------------------------------------------------------
    // fetch sequencer states, gray along idle -> request -> gap
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b00,
        FETCH_REQ  = 2'b01,
        FETCH_GAP  = 2'b11
    } fetch_state_e;

endpackage : hist_regs_pkg

// File: rtl/hist_entry_ram.sv
// histogram result memory: one write port, one registered read port
module hist_entry_ram
    import hist_regs_pkg::*;
#(
    parameter int unsigned IDX_W  = ENTRY_IDX_W,
    parameter int unsigned DATA_W = ENTRY_DATA_W
)
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              arst_n_i,
    // accumulation side
    input  wire logic              wr_en_i,
    input  wire logic [IDX_W-1:0]  wr_idx_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    // read side
    input  wire logic [IDX_W-1:0]  rd_idx_i,
    output logic      [DATA_W-1:0] rd_data_o
);

    logic [DATA_W-1:0] mem_r [2**IDX_W];

    always_ff @(posedge clk_sys_i)
    begin
        if (wr_en_i)
        begin
            mem_r[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_data_o <= '0;
        end
        else
        begin
            rd_data_o <= mem_r[rd_idx_i];
        end
    end

endmodule : hist_entry_ram

// File: verif/dma_mem_model.sv
// line-read memory model that answers the fetch requests
module dma_mem_model
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    // request side
    input  wire logic       dma_req_i,
    input  wire logic [3:0] ack_dly_i,
    output logic            dma_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_r;

    // ack is one cycle wide: the request must drop after the accepting edge
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wait_r    <= 4'h0;
            dma_ack_o <= 1'b0;
        end
        else if (!dma_req_i || dma_ack_o)
        begin
            wait_r    <= 4'h0;
            dma_ack_o <= 1'b0;
        end
        else if (wait_r == ack_dly_i)
            dma_ack_o <= 1'b1;
        else
            wait_r <= wait_r + 4'h1;
    end
endmodule : dma_mem_model

// File: verif/hist_mem_input_regs_bench.sv
// self-checking bench for the histogram memory-input register bank
module hist_mem_input_regs_bench
    import hist_regs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic                    clk_sys = 1'b0;
    logic                    arst_n = 1'b0;
    logic [REG_ADDR_W-1:0]   reg_addr = 8'h00;
    logic [REG_DATA_W-1:0]   reg_wdata = 32'h0000_0000;
    logic                    reg_wr = 1'b0;
    logic                    reg_rd = 1'b0;
    logic [REG_DATA_W-1:0]   reg_rdata;
    logic                    hist_wr = 1'b0;
    logic [ENTRY_IDX_W-1:0]  hist_idx = 10'h000;
    logic [ENTRY_DATA_W-1:0] histogram_entry_value = 20'h00000;
    logic                    frame_start = 1'b0;
    logic                    busy, frame_done, dma_req, dma_ack;
    logic [FETCH_ADDR_W-1:0] dma_addr;
    logic [SIZE_W-1:0]       dma_len;
    logic [3:0]              ack_dly = 4'h0;
    int                      seed = 32'h76860fda;
    int                      failures = 0;
    int                      total_checks = 0;
    int                      frames = 0;
    int                      started = 0;
    int                      mdl_start, mdl_stride, mdl_hs, mdl_vs, mdl_idx;
    int                      mdl_busy, exp_len, mdl_last;
    int                      mdl_mem [int];
    int unsigned             exp_q [$];
    logic [7:0]              ofs_tab [6] = '{OFS_ENTRY_INDEX, OFS_FETCH_START,
                                 OFS_LINE_STRIDE, OFS_FRAME_SIZE, 8'h18, 8'hFC};

    always #12.5 clk_sys = ~clk_sys;

    hist_mem_input_regs hist_mem_input_regs_i
    (
        .clk_sys_i      (clk_sys),
        .arst_n_i       (arst_n),
        .reg_addr_i     (reg_addr),
        .reg_wdata_i    (reg_wdata),
        .reg_wr_i       (reg_wr),
        .reg_rd_i       (reg_rd),
        .reg_rdata_o    (reg_rdata),
        .hist_wr_i      (hist_wr),
        .hist_wr_idx_i  (hist_idx),
        .hist_wr_data_i (histogram_entry_value),
        .frame_start_i  (frame_start),
        .busy_o         (busy),
        .frame_done_o   (frame_done),
        .dma_req_o      (dma_req),
        .dma_addr_o     (dma_addr),
        .dma_len_o      (dma_len),
        .dma_ack_i      (dma_ack)
    );

    dma_mem_model dma_mem_model_i
    (
        .clk_sys_i (clk_sys),
        .arst_n_i  (arst_n),
        .dma_req_i (dma_req),
        .ack_dly_i (ack_dly),
        .dma_ack_o (dma_ack)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    function automatic void mdl_write(input logic [7:0]  addr,
                                      input logic [31:0] data);
        case (addr)
            OFS_ENTRY_INDEX: mdl_idx = data & 32'h3FF;
            OFS_FETCH_START: mdl_start = data & 32'hFFFF_FFE0;
            OFS_LINE_STRIDE: mdl_stride = data & 32'hFFE0;
            OFS_FRAME_SIZE:
            begin
                mdl_hs = (data >> 16) & 32'h3FFF;
                mdl_vs = data & 32'h3FFF;
            end
            default: ;
        endcase
    endfunction : mdl_write

    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        mdl_write(addr, data);
    endtask : reg_write

    // write strobe then read strobe with no idle cycle between them
    task automatic wr_rd(input logic [7:0] waddr, input logic [31:0] data,
                         input logic [7:0] raddr);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= waddr;
        reg_wdata <= data;
        @(posedge clk_sys);
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= raddr;
        mdl_write(waddr, data);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, mdl_read(raddr));
    endtask : wr_rd

    function automatic logic [31:0] mdl_read(input logic [7:0] addr);
        case (addr)
            OFS_ENTRY_INDEX: return mdl_idx;
            OFS_ENTRY_VALUE: return mdl_mem[mdl_idx] & 32'hF_FFFF;
            OFS_FETCH_START: return mdl_start;
            OFS_LINE_STRIDE: return mdl_stride;
            OFS_FRAME_SIZE:  return (mdl_hs << 16) | mdl_vs;
            OFS_FETCH_STAT:  return (mdl_busy << 31) | mdl_last;
            default:         return 32'h0000_0000;
        endcase
    endfunction : mdl_read

    // read data stand only in the cycle after the strobe
    task automatic rd_check(input logic [7:0] addr);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, mdl_read(addr));
    endtask : rd_check

    task automatic hist_put(input logic [9:0] idx, input logic [19:0] data);
        @(posedge clk_sys);
        hist_wr   <= 1'b1;
        hist_idx  <= idx;
        histogram_entry_value <= data;
        @(posedge clk_sys);
        hist_wr <= 1'b0;
        mdl_mem[idx] = data;
    endtask : hist_put

    // decided after the edge so the done monitor has already run
    task automatic start_frame();
        int k;
        @(posedge clk_sys);
        frame_start <= 1'b1;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        #1;
        if (mdl_busy == 0 && mdl_hs != 0 && mdl_vs != 0)
        begin
            mdl_busy = 1;
            started++;
            exp_len = mdl_hs;
            mdl_last = mdl_vs - 1;
            for (k = 0; k < mdl_vs; k++)
                exp_q.push_back(mdl_start + k * mdl_stride);
            check(busy, 1'b1);
        end
        else if (mdl_busy == 0)
            check(busy, 1'b0);
    endtask : start_frame

    task automatic wait_frames(input int n);
        int t;
        for (t = 0; t < 3000 && frames < n; t++)
            @(posedge clk_sys);
        check(frames, n);
    endtask : wait_frames

    // ------------------------------------------------------------------
    // line request monitor
    // ------------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (dma_req && dma_ack)
        begin
            check(dma_addr,
                  exp_q.size() ? exp_q.pop_front() : 32'hDEAD_BEEF);
            check(dma_len, exp_len);
        end
        if (frame_done)
        begin
            check(exp_q.size(), 0);
            frames++;
            mdl_busy = 0;
        end
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        int n;
        int i;
        logic [31:0] v;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (i = 0; i < 6; i++)
            rd_check(ofs_tab[i]);
        $display("test reset_values done");
        for (n = 0; n < 8; n++)
            for (i = 0; i < 5; i++)
            begin
                v = $random(seed);
                wr_rd(ofs_tab[i], v, ofs_tab[i]);
            end
        $display("test field_masks done");
        for (n = 0; n < 6; n++)
        begin
            v = $random(seed);
            i = (n == 0) ? 0 : (n == 1) ? 32'h3FF : v[9:0];
            hist_put(10'(i), v[31:12]);
            wr_rd(OFS_ENTRY_INDEX, {v[31:10], 10'(i)},
                  OFS_ENTRY_VALUE);
            reg_write(OFS_ENTRY_VALUE, ~v);
            rd_check(OFS_ENTRY_VALUE);
        end
        $display("test entry_readout done");
        reg_write(OFS_FETCH_START, $random(seed));
        reg_write(OFS_LINE_STRIDE, $random(seed));
        reg_write(OFS_FRAME_SIZE, 32'h0010_0003);
        for (n = 0; n < 6; n++)
        begin
            ack_dly <= 4'($random(seed) & 7);
            start_frame();
            reg_write(OFS_FETCH_START, $random(seed));
            reg_write(OFS_LINE_STRIDE, $random(seed));
            v = $random(seed);
            reg_write(OFS_FRAME_SIZE,
                      (v & 32'hFFFF_0000) | 32'h1_0000 | ((v & 3) + 1));
            rd_check(OFS_FETCH_START);
            rd_check(OFS_LINE_STRIDE);
            rd_check(OFS_FRAME_SIZE);
            start_frame();
            wait_frames(started);
            rd_check(OFS_FETCH_STAT);
        end
        reg_write(OFS_FRAME_SIZE, 32'h3FFF_0000);
        start_frame();
        reg_write(OFS_FRAME_SIZE, 32'h0000_0005);
        start_frame();
        repeat (20) @(posedge clk_sys);
        check(frames, started);
        $display("test frame_fetch done");
        print_verdict();
    end
endmodule : hist_mem_input_regs_bench
